// File: logic/cses_pkg.sv
// package for the subchannel error and status unit
// assumes one synchronous clock domain; no imports anywhere
//
// Summary of operation
// - software errors set program check bit 42
// - subchannel status at bits 40-47, bits combine
// - address exception on data word: program check
// - invalid command code raises program check
// - zero byte count raises program check
// - jump to jump, or bad first descriptor
// - reserved descriptor bits or bad instruction
// - key violation sets protection check bit 43
// - storage flags key violation on mismatch rules
// - input or data-word storage parity sets bit 44
// - bad-parity output byte driven with even parity
// - data check stops chaining, not the transfer
// - bad address/status parity sets bit 45; unit-initiated address outside selector mode: reset only
// - returned address mismatch: interface control check
// - chained selection not operational or busy: check
// - mistimed or overlong device signal: check
// - interface check resets device, reports or pends
// - control check code in bits 46-47
// - control check sources, output only when sent
// - keep first control check code only
// - remaining byte count into bits 48-63
// - transfer errors answer service with terminate
// - first selection errors: reset, initiation status
// - chained selection errors: reset/pend or pseudo test
package cses_pkg;

    // status word bit positions (bit 0 is the msb of 64)
    localparam int SB_PCI = 40;
    localparam int SB_LEN = 41;
    localparam int SB_PROG = 42;
    localparam int SB_PROT = 43;
    localparam int SB_DATA = 44;
    localparam int SB_IFC = 45;
    localparam int SB_CC0 = 46;
    localparam int SB_CC1 = 47;
    localparam int DESC_RSV_LO = 37;
    localparam int DESC_RSV_HI = 39;
    localparam int DESC_CMD_LO = 4;
    localparam int DESC_CMD_HI = 7;

    localparam logic [1:0] CC_NONE = 2'h0;
    localparam logic [1:0] CC_DATA = 2'h1;
    localparam logic [1:0] CC_PTR = 2'h2;
    localparam logic [1:0] CC_DESC = 2'h3;

    localparam logic [3:0] CMD_JUMP = 4'h8;
    localparam logic [3:0] CMD_NONE = 4'h0;

    // longest a device tag may stay up before it counts as stuck
    localparam int TAG_LIMIT_NS = 2000;
    localparam int CLK_NS = 10;
    localparam int TAG_LIMIT_CYC = TAG_LIMIT_NS / CLK_NS;
    localparam logic [15:0] TAG_LIMIT = 16'(TAG_LIMIT_CYC);

    // register map on the plain port
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_COUNT = 4'h1;
    localparam logic [3:0] REG_CTRL = 4'h2;
    localparam logic [3:0] REG_FLAGS = 4'h3;
    localparam logic [15:0] CTRL_RESET = 16'h0000;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_FIRST_SEL = 2'b01,
        PH_CHAIN_SEL = 2'b10,
        PH_XFER = 2'b11
    } cses_phase_type;

    typedef enum logic [1:0] {
        ACC_DATA = 2'b00,
        ACC_DESC = 2'b01,
        ACC_PTR = 2'b10,
        ACC_RELOC = 2'b11
    } cses_acc_type;

    // one storage access result
    typedef struct packed {
        logic valid;
        cses_acc_type kind;
        logic write;
        logic addr_exc;
        logic prot_exc;
        logic parity;
        logic addr_check;
        logic byte_sent;
    } cses_storage_type;

    // fetched descriptor summary
    typedef struct packed {
        logic valid;
        logic [3:0] cmd;
        logic [2:0] rsv;
        logic [15:0] count;
        logic pci;
        logic first;
    } cses_desc_type;

    // interface events from the device side
    typedef struct packed {
        logic addr_valid;
        logic [7:0] addr;
        logic addr_par;
        logic status_valid;
        logic [7:0] status;
        logic status_par;
        logic not_oper;
        logic unit_init;
        logic tag_active;
        logic tag_wrong;
        logic service_in;
        logic in_par_bad;
    } cses_link_type;

    typedef struct packed {
        cses_phase_type phase;
        logic selector;
        logic [7:0] sent_addr;
        logic prev_jump;
        logic [7:0] sc_bits;
        logic [1:0] cc_code;
        logic [15:0] count;
        logic chain_ok;
        logic terminate;
        logic disc_reset;
        logic pseudo_test;
        logic int_pend;
        logic isw_sel;
        logic even_par;
        logic [15:0] tag_timer;
        logic [15:0] ctrl;
        logic [31:0] rdata;
        logic [15:0] flags_seen;
    } cses_state_type;

endpackage : cses_pkg

// File: logic/cses_unit.sv
// error detection and subchannel status assembly for one channel
// assumes synchronous inputs on sys_clk; storage reports its own
// exceptions, the sequencer supplies phase and access results
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ns
module cses_unit (
    input wire logic sys_clk,
    input wire logic reset,
    input wire cses_pkg::cses_phase_type phase,
    input wire logic selector_mode,
    input wire logic [7:0] sent_addr,
    input wire logic bad_instr,
    input wire logic [3:0] chan_key,
    input wire logic [3:0] loc_key,
    input wire logic loc_read_prot,
    input wire logic stor_req,
    input wire logic stor_write,
    input wire cses_pkg::cses_storage_type stor,
    input wire cses_pkg::cses_desc_type desc,
    input wire logic [15:0] hard_count,
    input wire logic byte_dec,
    input wire cses_pkg::cses_link_type link,
    input wire logic status_write,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic key_violation,
    output logic [7:0] subchannel_status,
    output logic [15:0] remaining_count,
    output logic chain_allowed,
    output logic terminate_tag,
    output logic disconnect_reset,
    output logic pseudo_test,
    output logic interrupt_pending,
    output logic report_in_isw,
    output logic force_even_parity,
    output logic [31:0] reg_rdata
);

    cses_pkg::cses_state_type state_reg;
    cses_pkg::cses_state_type state_next;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // status bit n (40..47) sits at vector index 47-n
    function automatic logic [2:0] sc_idx(input int n);
        sc_idx = 3'(47 - n);
    endfunction : sc_idx

    function automatic logic [1:0] cc_of(input cses_pkg::cses_acc_type k);
        case (k)
            cses_pkg::ACC_DATA: cc_of = cses_pkg::CC_DATA;
            cses_pkg::ACC_PTR: cc_of = cses_pkg::CC_PTR;
            default: cc_of = cses_pkg::CC_DESC;
        endcase
    endfunction : cc_of

    // ------------------------------------------------------------
    // error detection
    // ------------------------------------------------------------
    logic kv;
    logic out_ok;
    logic prog_err;
    logic prot_err;
    logic data_err;
    logic ifc_err;
    logic cc_err;
    logic silent_reset;
    logic busy_cu;
    logic tag_long;
    logic grave;

    always_comb
    begin
        // write-only protection never faults a read
        kv = stor_req && (chan_key != loc_key)
            && (stor_write || loc_read_prot);
        // output reads only count when a byte of the word goes out
        out_ok = stor.write || stor.byte_sent || (stor.kind != cses_pkg::ACC_DATA);
        prog_err = (stor.valid && out_ok && stor.addr_exc
            && stor.kind inside {cses_pkg::ACC_DATA, cses_pkg::ACC_DESC})
            || (desc.valid && desc.cmd == cses_pkg::CMD_NONE)
            || (desc.valid && desc.count == 16'h0000)
            || (desc.valid && desc.cmd == cses_pkg::CMD_JUMP
                && state_reg.prev_jump)
            || (desc.valid && desc.first
                && (desc.cmd == cses_pkg::CMD_JUMP || desc.pci))
            || (desc.valid && desc.rsv != 3'h0)
            || bad_instr;
        prot_err = stor.valid && out_ok && stor.prot_exc
            && stor.kind inside {cses_pkg::ACC_DATA, cses_pkg::ACC_DESC};
        data_err = (link.service_in && link.in_par_bad)
            || (stor.valid && stor.kind == cses_pkg::ACC_DATA
                && stor.parity && out_ok);
        cc_err = stor.valid && out_ok && (
            (stor.kind == cses_pkg::ACC_DATA && stor.addr_check)
            || (stor.kind == cses_pkg::ACC_DESC && (stor.addr_check || stor.parity))
            || (stor.kind inside {cses_pkg::ACC_PTR, cses_pkg::ACC_RELOC}
                && (stor.addr_exc || stor.prot_exc || stor.parity
                    || stor.addr_check)));
        // even parity on a unit-initiated address outside selector mode has no owner
        silent_reset = link.addr_valid && !(^{link.addr, link.addr_par}) && link.unit_init
            && !selector_mode;
        busy_cu = link.status_valid && link.status[7 - 3] && link.status[7 - 1];
        tag_long = link.tag_active && state_reg.tag_timer >= cses_pkg::TAG_LIMIT;
        // a byte whose overall parity is even is bad
        ifc_err = (link.addr_valid && !(^{link.addr, link.addr_par}) && !silent_reset)
            || (link.status_valid && !(^{link.status, link.status_par}))
            || (phase != cses_pkg::PH_IDLE && link.addr_valid
                && link.addr != sent_addr)
            || (phase == cses_pkg::PH_CHAIN_SEL
                && (link.not_oper || busy_cu))
            || link.tag_wrong || tag_long;
        grave = prog_err || prot_err || cc_err;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        state_next.phase = phase;
        state_next.selector = selector_mode;
        state_next.sent_addr = sent_addr;
        state_next.terminate = 1'b0;
        state_next.disc_reset = 1'b0;
        state_next.pseudo_test = 1'b0;
        state_next.even_par = 1'b0;
        if (desc.valid)
        begin
            state_next.prev_jump = (desc.cmd == cses_pkg::CMD_JUMP);
        end
        state_next.tag_timer = link.tag_active
            ? (state_reg.tag_timer == 16'hffff ? state_reg.tag_timer
               : 16'(state_reg.tag_timer + 16'h0001))
            : 16'h0000;
        if (byte_dec && state_reg.count != 16'h0000)
        begin
            state_next.count = 16'(state_reg.count - 16'h0001);
        end
        if (desc.valid)
        begin
            state_next.count = desc.count;
        end
        // a written word clears the bits; new errors this cycle survive
        if (status_write)
        begin
            state_next.sc_bits = 8'h00;
            state_next.cc_code = cses_pkg::CC_NONE;
            state_next.chain_ok = 1'b1;
            state_next.isw_sel = 1'b0;
            if (state_reg.ctrl[0])
            begin
                state_next.int_pend = 1'b0;
            end
        end
        // software clears come before the sets so a new event wins
        if (reg_write && reg_addr == cses_pkg::REG_FLAGS)
        begin
            state_next.flags_seen = 16'h0000;
            if (reg_wdata[0])
            begin
                state_next.int_pend = 1'b0;
            end
        end
        if (desc.valid && desc.pci)
        begin
            state_next.sc_bits[sc_idx(cses_pkg::SB_PCI)] = 1'b1;
        end
        // bits accumulate independently, several may be set together
        if (prog_err)
        begin
            state_next.sc_bits[sc_idx(cses_pkg::SB_PROG)] = 1'b1;
        end
        if (prot_err)
        begin
            state_next.sc_bits[sc_idx(cses_pkg::SB_PROT)] = 1'b1;
        end
        if (data_err)
        begin
            state_next.sc_bits[sc_idx(cses_pkg::SB_DATA)] = 1'b1;
            state_next.chain_ok = 1'b0;
        end
        if (stor.valid && stor.kind == cses_pkg::ACC_DATA && stor.parity
            && !stor.write && stor.byte_sent)
        begin
            state_next.even_par = 1'b1;
        end
        if (ifc_err)
        begin
            state_next.sc_bits[sc_idx(cses_pkg::SB_IFC)] = 1'b1;
            state_next.disc_reset = 1'b1;
            if (phase == cses_pkg::PH_FIRST_SEL)
            begin
                state_next.isw_sel = 1'b1;
            end
            else
            begin
                state_next.int_pend = 1'b1;
            end
        end
        if (silent_reset)
        begin
            state_next.disc_reset = 1'b1;
        end
        if (cc_err && state_next.cc_code == cses_pkg::CC_NONE)
        begin
            state_next.cc_code = cc_of(stor.kind);
        end
        if (grave)
        begin
            case (phase)
                cses_pkg::PH_XFER:
                begin
                    state_next.terminate = link.service_in;
                end
                cses_pkg::PH_FIRST_SEL:
                begin
                    state_next.disc_reset = 1'b1;
                    state_next.isw_sel = 1'b1;
                end
                cses_pkg::PH_CHAIN_SEL:
                begin
                    if (selector_mode)
                    begin
                        state_next.disc_reset = 1'b1;
                        state_next.int_pend = 1'b1;
                    end
                    else
                    begin
                        state_next.pseudo_test = 1'b1;
                    end
                end
                default:
                begin
                    state_next.terminate = 1'b0;
                end
            endcase
        end
        if (grave || ifc_err)
        begin
            state_next.flags_seen = 16'(state_next.flags_seen + 16'h0001);
        end
        if (reg_write && reg_addr == cses_pkg::REG_CTRL)
        begin
            state_next.ctrl = reg_wdata[15:0];
        end
        state_next.rdata = 32'h0000_0000;
        if (reg_read)
        begin
            case (reg_addr)
                cses_pkg::REG_STATUS:
                    state_next.rdata = {16'h0000, state_reg.sc_bits[7:2],
                        state_reg.cc_code, 8'h00};
                cses_pkg::REG_COUNT:
                    state_next.rdata = {16'h0000, state_reg.count};
                cses_pkg::REG_CTRL:
                    state_next.rdata = {16'h0000, state_reg.ctrl};
                cses_pkg::REG_FLAGS:
                    state_next.rdata = {state_reg.flags_seen, 12'h000,
                        state_reg.int_pend, state_reg.isw_sel,
                        state_reg.chain_ok, state_reg.selector};
                default:
                    state_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state_reg <= '0;
            state_reg.chain_ok <= 1'b1;
            state_reg.ctrl <= cses_pkg::CTRL_RESET;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign key_violation = kv;
    assign subchannel_status = {state_reg.sc_bits[7:2], state_reg.cc_code};
    assign remaining_count = hard_count;
    assign chain_allowed = state_reg.chain_ok;
    assign terminate_tag = state_reg.terminate;
    assign disconnect_reset = state_reg.disc_reset;
    assign pseudo_test = state_reg.pseudo_test;
    assign interrupt_pending = state_reg.int_pend;
    assign report_in_isw = state_reg.isw_sel;
    assign force_even_parity = state_reg.even_par;
    assign reg_rdata = state_reg.rdata;

endmodule : cses_unit

// File: dv/cses_properties.sv
// assertion checker for the subchannel error unit, bound to its top
// assumes cses_pkg compiled first and a single clock domain
`timescale 1ns/1ns
module cses_properties (
    input wire logic sys_clk,
    input wire logic reset,
    input wire cses_pkg::cses_phase_type phase,
    input wire logic [7:0] sent_addr,
    input wire logic [3:0] chan_key,
    input wire logic [3:0] loc_key,
    input wire logic loc_read_prot,
    input wire logic stor_req,
    input wire logic stor_write,
    input wire cses_pkg::cses_storage_type stor,
    input wire cses_pkg::cses_desc_type desc,
    input wire logic [15:0] hard_count,
    input wire cses_pkg::cses_link_type link,
    input wire logic status_write,
    input wire logic key_violation,
    input wire logic [7:0] subchannel_status,
    input wire logic [15:0] remaining_count,
    input wire logic terminate_tag,
    input wire logic disconnect_reset,
    input wire logic force_even_parity
);
// ----------
// error reactions
// ----------
default clocking @(posedge sys_clk); endclocking
default disable iff (reset);
logic data_acc;
logic good_addr;
assign data_acc = stor.valid && stor.kind == cses_pkg::ACC_DATA;
// only a well-formed address byte may be judged against the sent one
assign good_addr = link.addr_valid && ^{link.addr, link.addr_par};
prog_data_a: assert property (data_acc && stor.write && stor.addr_exc
    |=> subchannel_status[5]) else $error("no program check on data address fault");
zero_count_a: assert property (desc.valid && desc.count == 16'h0000
    |=> subchannel_status[5]) else $error("no program check on zero count");
prot_write_a: assert property (stor.valid && stor.write && stor.prot_exc
    && stor.kind inside {cses_pkg::ACC_DATA, cses_pkg::ACC_DESC}
    |=> subchannel_status[4]) else $error("no protection check on write");
key_rule_a: assert property (stor_req |-> key_violation ==
    (chan_key != loc_key && (stor_write || loc_read_prot))) else $error("key check wrong");
even_par_a: assert property (data_acc && !stor.write && stor.parity && stor.byte_sent
    |=> force_even_parity && subchannel_status[3]) else $error("bad byte not flagged");
cc_first_a: assert property (subchannel_status[1:0] != 2'h0 && !status_write
    |=> $stable(subchannel_status[1:0])) else $error("control check code replaced");
count_out_a: assert property (remaining_count == hard_count)
    else $error("remaining count differs");
addr_cmp_a: assert property (phase == cses_pkg::PH_FIRST_SEL && good_addr
    && link.addr != sent_addr |=> subchannel_status[2] && disconnect_reset)
    else $error("address mismatch not handled");
term_tag_a: assert property (phase == cses_pkg::PH_XFER && link.service_in
    && data_acc && stor.write && stor.addr_exc |=> terminate_tag)
    else $error("no terminate answer");
cover property (terminate_tag);
cover property (disconnect_reset);
cover property (force_even_parity);
endmodule : cses_properties

bind cses_unit cses_properties u_props (
    .sys_clk(sys_clk),
    .reset(reset),
    .phase(phase),
    .sent_addr(sent_addr),
    .chan_key(chan_key),
    .loc_key(loc_key),
    .loc_read_prot(loc_read_prot),
    .stor_req(stor_req),
    .stor_write(stor_write),
    .stor(stor),
    .desc(desc),
    .hard_count(hard_count),
    .link(link),
    .status_write(status_write),
    .key_violation(key_violation),
    .subchannel_status(subchannel_status),
    .remaining_count(remaining_count),
    .terminate_tag(terminate_tag),
    .disconnect_reset(disconnect_reset),
    .force_even_parity(force_even_parity)
);

// File: dv/cses_pcu_model.sv
// peripheral control unit model driving the error unit's link input
// assumes the bench calls one task at a time, from any point in a cycle
`timescale 1ns/1ns
module cses_pcu_model (
    input wire logic sys_clk,
    output cses_pkg::cses_link_type link
);
// ----------
// device replies
// ----------
initial link = '0;

// k: 0 address, 1 unit-initiated address, 2 status, 3 not operational,
// 4 service request, 5 mistimed tag; dly gives a slow answer
task automatic put(input int k, input logic [7:0] v, input logic bad, input int dly);
    cses_pkg::cses_link_type l;
    l = link;
    repeat (dly) @(posedge sys_clk);
    l.addr = v;
    l.status = v;
    l.addr_par = ~^v ^ bad; // odd parity unless told to break it
    l.status_par = ~^v ^ bad;
    l.addr_valid = k < 2;
    l.unit_init = k == 1;
    l.status_valid = k == 2;
    l.not_oper = k == 3;
    l.service_in = k == 4;
    l.in_par_bad = bad && k == 4;
    l.tag_wrong = k == 5; // mistimed only when told to
    @(posedge sys_clk);
    link <= l;
    @(posedge sys_clk);
    // released bytes turn over so a stale value never looks valid
    l = '0;
    l.addr = ~v;
    l.status = ~v;
    l.tag_active = link.tag_active;
    link <= l;
    #1;
endtask : put

task automatic tag_hold(input int n);
    @(posedge sys_clk);
    link.tag_active <= 1'h1;
    repeat (n) @(posedge sys_clk);
    link.tag_active <= 1'h0; // dropped after n cycles
    #1;
endtask : tag_hold
endmodule : cses_pcu_model

// File: dv/tb.sv
// bench for the subchannel error unit: error events and register port
// assumes cses_pkg, the checker and the device model compiled before
`timescale 1ns/1ns
module tb;
logic sys_clk, reset, selector_mode, bad_instr, loc_read_prot, stor_req;
logic stor_write, byte_dec, status_write, reg_write, reg_read;
logic key_violation, chain_allowed, terminate_tag, disconnect_reset;
logic pseudo_test, interrupt_pending, report_in_isw, force_even_parity;
logic [7:0] sent_addr, subchannel_status;
logic [3:0] chan_key, loc_key, reg_addr;
logic [15:0] hard_count, remaining_count;
logic [31:0] reg_wdata, reg_rdata;
cses_pkg::cses_phase_type phase;
cses_pkg::cses_storage_type stor;
cses_pkg::cses_desc_type desc;
cses_pkg::cses_link_type link;
cses_pkg::cses_desc_type dl [6];
logic [1:0] cc [4];
int failures, checks, n;

cses_unit dut (
    .sys_clk(sys_clk),
    .reset(reset),
    .phase(phase),
    .selector_mode(selector_mode),
    .sent_addr(sent_addr),
    .bad_instr(bad_instr),
    .chan_key(chan_key),
    .loc_key(loc_key),
    .loc_read_prot(loc_read_prot),
    .stor_req(stor_req),
    .stor_write(stor_write),
    .stor(stor),
    .desc(desc),
    .hard_count(hard_count),
    .byte_dec(byte_dec),
    .link(link),
    .status_write(status_write),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .key_violation(key_violation),
    .subchannel_status(subchannel_status),
    .remaining_count(remaining_count),
    .chain_allowed(chain_allowed),
    .terminate_tag(terminate_tag),
    .disconnect_reset(disconnect_reset),
    .pseudo_test(pseudo_test),
    .interrupt_pending(interrupt_pending),
    .report_in_isw(report_in_isw),
    .force_even_parity(force_even_parity),
    .reg_rdata(reg_rdata)
);
cses_pcu_model pcu (.sys_clk(sys_clk), .link(link));

initial
begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
end
// ----------
// helpers
// ----------
task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
        failures++;
        $display("[FAIL] %0t: got %h, want %h", $time, seen, exp);
    end
endtask : chk

task automatic test_done;
    if (failures == 0 && checks > 0)
        $display("STATUS OK");
    else
        $display("STATUS NOT OK");
    $finish;
endtask : test_done

task automatic rst;
    @(posedge sys_clk);
    reset <= 1'h1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'h0;
endtask : rst

// b = {write, addr_exc, prot_exc, parity, addr_check, byte_sent}
task automatic sp(input int k, input logic [5:0] b);
    @(posedge sys_clk);
    stor <= {1'h1, 2'(k), b};
    @(posedge sys_clk);
    stor <= '0;
    #1;
endtask : sp

task automatic dp(input cses_pkg::cses_desc_type d, input logic w);
    @(posedge sys_clk);
    desc <= d;
    status_write <= w;
    @(posedge sys_clk);
    desc <= '0;
    status_write <= 1'h0;
    #1;
endtask : dp

task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_write <= w;
    reg_read <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    {reg_write, reg_read} <= 2'h0;
    #1;
    if (!w)
        chk(reg_rdata, d);
endtask : acc
// ----------
// sequence
// ----------
initial
begin
    {reset, selector_mode, bad_instr, loc_read_prot, stor_req, stor_write} = 6'h20;
    {byte_dec, status_write, reg_write, reg_read, reg_addr} = 8'h00;
    phase = cses_pkg::PH_IDLE;
    {sent_addr, chan_key, loc_key, hard_count} = 32'h5A33_BEEF;
    {reg_wdata, stor, desc} = '0;
    {failures, checks} = '0;
    dl = '{{1'h1, 4'h1, 3'h0, 16'h0010, 2'h0}, {1'h1, 4'h0, 3'h0, 16'h0010, 2'h0},
        {1'h1, 4'h1, 3'h0, 16'h0000, 2'h0}, {1'h1, 4'h1, 3'h5, 16'h0010, 2'h0},
        {1'h1, 4'h1, 3'h0, 16'h0010, 2'h3}, {1'h1, 4'h8, 3'h0, 16'h0010, 2'h1}};
    cc = '{2'h1, 2'h3, 2'h2, 2'h3};
    repeat (2) @(posedge sys_clk);
    reset <= 1'h0;
    #1;
    chk({subchannel_status, chain_allowed}, 9'h001);
    acc(1'h0, cses_pkg::REG_STATUS, 32'h0000_0000);
    acc(1'h0, 4'hF, 32'h0000_0000);
    stor_req <= 1'h1;
    for (int i = 0; i < 8; i++)
    begin
        @(posedge sys_clk);
        stor_write <= i[0];
        loc_read_prot <= i[1];
        loc_key <= i[2] ? 4'h6 : 4'h3;
        #1;
        chk(key_violation, i[2] && (i[0] || i[1]));
    end
    stor_req <= 1'h0;
    for (int i = 0; i < 6; i++)
    begin
        rst;
        dp(dl[i], 1'h0);
        chk(subchannel_status[5], i != 0);
    end
    rst;
    dp({1'h1, 4'h8, 3'h0, 16'h0010, 2'h0}, 1'h0);
    chk(subchannel_status[5], 1'h0);
    dp({1'h1, 4'h8, 3'h0, 16'h0010, 2'h0}, 1'h0);
    chk(subchannel_status[5], 1'h1);
    @(posedge sys_clk);
    byte_dec <= 1'h1;
    @(posedge sys_clk);
    byte_dec <= 1'h0;
    acc(1'h0, cses_pkg::REG_COUNT, 32'h0000_000F);
    rst;
    phase <= cses_pkg::PH_FIRST_SEL;
    @(posedge sys_clk);
    bad_instr <= 1'h1;
    @(posedge sys_clk);
    bad_instr <= 1'h0;
    #1;
    chk({subchannel_status, disconnect_reset, report_in_isw}, 10'h083);
    dp('0, 1'h1);
    chk({subchannel_status, remaining_count}, 24'h00_BEEF);
    for (int s = 0; s < 2; s++)
    begin
        rst;
        phase <= cses_pkg::PH_CHAIN_SEL;
        selector_mode <= s[0];
        dp(dl[2], 1'h0);
        chk({pseudo_test, disconnect_reset, interrupt_pending}, s ? 3'h3 : 3'h4);
    end
    acc(1'h1, cses_pkg::REG_FLAGS, 32'h0000_0001);
    chk(interrupt_pending, 1'h0);
    rst;
    phase <= cses_pkg::PH_XFER;
    sp(0, 6'h10);
    chk(subchannel_status, 8'h00);
    sp(0, 6'h11);
    sp(0, 6'h28);
    chk(subchannel_status[5:4], 2'h3);
    fork
        pcu.put(4, 8'h00, 1'h0, 0);
        sp(0, 6'h30);
    join
    chk(terminate_tag, 1'h1);
    rst;
    pcu.put(4, 8'h00, 1'h1, 0);
    chk(subchannel_status[3], 1'h1);
    dp('0, 1'h1);
    fork
        pcu.put(4, 8'h00, 1'h0, 0);
        sp(0, 6'h05);
    join
    chk({force_even_parity, terminate_tag, chain_allowed, subchannel_status[3]}, 4'h9);
    for (int k = 0; k < 4; k++)
    begin
        rst;
        sp(k, k == 1 ? 6'h04 : 6'h22);
        chk(subchannel_status[1:0], cc[k]);
    end
    sp(0, 6'h22);
    chk(subchannel_status[1:0], 2'h3);
    dp('0, 1'h1);
    sp(0, 6'h02);
    sp(2, 6'h10);
    chk(subchannel_status[1:0], 2'h2);
    rst;
    phase <= cses_pkg::PH_FIRST_SEL;
    pcu.put(0, 8'h5A, 1'h0, 0);
    chk(subchannel_status[2], 1'h0);
    pcu.put(0, 8'h5B, 1'h0, 3);
    chk({subchannel_status[2], disconnect_reset, report_in_isw}, 3'h7);
    rst;
    phase <= cses_pkg::PH_XFER;
    pcu.put(2, 8'h0C, 1'h1, 0);
    chk(subchannel_status[2], 1'h1);
    rst;
    pcu.put(5, 8'h00, 1'h0, 0);
    chk(subchannel_status[2], 1'h1);
    rst;
    phase <= cses_pkg::PH_IDLE;
    selector_mode <= 1'h0;
    pcu.put(1, 8'h33, 1'h1, 0);
    chk({subchannel_status[2], disconnect_reset}, 2'h1);
    for (int k = 2; k < 4; k++)
    begin
        rst;
        phase <= cses_pkg::PH_CHAIN_SEL;
        selector_mode <= 1'h1;
        pcu.put(k, 8'h50, 1'h0, 1);
        chk({subchannel_status[2], interrupt_pending}, 2'h3);
    end
    acc(1'h1, cses_pkg::REG_CTRL, 32'h0000_0001);
    acc(1'h0, cses_pkg::REG_CTRL, 32'h0000_0001);
    dp('0, 1'h1);
    chk(interrupt_pending, 1'h0);
    rst;
    pcu.tag_hold(150);
    chk(subchannel_status[2], 1'h0);
    fork
        pcu.tag_hold(260);
    join_none
    n = 0;
    while (n < 240 && subchannel_status[2] !== 1'h1)
    begin
        @(posedge sys_clk);
        #1;
        n++;
    end
    chk(n > 150 && n < 240, 1'h1);
    test_done;
end
endmodule : tb
